// ### sesl_event_reg.sv
`timescale 1ns/100ps
// one event register with its enable mask and edge latch
module sesl_event_reg #(
   parameter int unsigned WIDTH = 16
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic [WIDTH-1:0] cond,
   input  wire logic             en_load,
   input  wire logic [WIDTH-1:0] en_value,
   input  wire logic [WIDTH-1:0] ev_clear,
   output logic      [WIDTH-1:0] enable,
   output logic      [WIDTH-1:0] events
);
   logic [WIDTH-1:0] cond_ff;
   logic [WIDTH-1:0] enable_ff;
   logic [WIDTH-1:0] events_ff;
   logic [WIDTH-1:0] rise;

   // ---------------------------------------------------------------
   // edge latch
   // ---------------------------------------------------------------
   assign rise = cond & ~cond_ff & enable_ff;

   // set wins over a clear in the same cycle
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cond_ff   <= '0;
         enable_ff <= WIDTH'(sesl_pkg::ENABLE_RST);
         events_ff <= '0;
      end else begin
         cond_ff   <= cond;
         events_ff <= (events_ff & ~ev_clear) | rise;
         if (en_load) begin
            enable_ff <= en_value;
         end
      end
   end

   assign enable = enable_ff;
   assign events = events_ff;
endmodule

// ### sesl_host_model.sv
`timescale 1ns/100ps
// ----------
// host side: one command at a time
// ----------
module sesl_host_model (
   input  wire logic        clk,
   input  wire logic        cmd_ready,
   input  wire logic        rsp_valid,
   input  wire logic [15:0] rsp_data,
   input  wire logic        rsp_error,
   output logic             cmd_valid,
   output logic [3:0]       cmd_code,
   output logic [3:0]       cmd_reg,
   output logic [3:0]       cmd_bit,
   output logic [15:0]      cmd_value
);
   // idle lines at time zero
   initial begin
      cmd_valid = 1'b0;
      {cmd_code, cmd_reg, cmd_bit, cmd_value} = 28'h0000000;
   end
   // request stands until taken; released lines show inverted values
   task automatic send(input logic [3:0] c, r, b, input logic [15:0] v,
                       output logic [15:0] d, output logic e);
      int n;
      logic late;
      n = 0;
      @(posedge clk);
      cmd_valid <= 1'b1;
      {cmd_code, cmd_reg, cmd_bit} <= {c, r, b}; // bit index 0..15
      cmd_value <= v; // bit 0 picks on or off
      do @(posedge clk); while (cmd_ready !== 1'b1 && n++ < 20);
      late = (cmd_ready !== 1'b1);
      cmd_valid <= 1'b0;
      {cmd_code, cmd_reg, cmd_bit, cmd_value} <= ~{c, r, b, v};
      do @(posedge clk); while (rsp_valid !== 1'b1 && n++ < 40);
      late = late || (rsp_valid !== 1'b1);
      // a missing handshake hands back unknowns so the bench counts a mismatch
      d = late ? 16'hxxxx : rsp_data;
      e = late ? 1'bx : rsp_error;
   endtask
endmodule

// ### sesl_pkg.sv
package sesl_pkg;
   // ---------------------------------------------------------------
   // sizes
   // ---------------------------------------------------------------
   localparam int unsigned NUM_REGS  = 10;
   localparam int unsigned REG_BITS  = 16;
   localparam int unsigned IDX_BITS  = 4;

   // ---------------------------------------------------------------
   // reset values
   // ---------------------------------------------------------------
   localparam logic [15:0] ENABLE_RST  = 16'hffff;
   localparam logic [9:0]  SERVICE_RST = 10'h000;

   // ---------------------------------------------------------------
   // command codes
   // ---------------------------------------------------------------
   typedef enum logic [3:0] {
      SESL_CMD_NONE       = 4'h0,
      SESL_CMD_EN_WR_ALL  = 4'h1,
      SESL_CMD_EN_WR_BIT  = 4'h2,
      SESL_CMD_EN_RD_ALL  = 4'h3,
      SESL_CMD_EN_RD_BIT  = 4'h4,
      SESL_CMD_EV_RD_ALL  = 4'h5,
      SESL_CMD_EV_RD_BIT  = 4'h6,
      SESL_CMD_GL_RD_ALL  = 4'h7,
      SESL_CMD_GL_RD_REG  = 4'h8,
      SESL_CMD_SM_WR_ALL  = 4'h9,
      SESL_CMD_SM_WR_REG  = 4'ha,
      SESL_CMD_SM_RD_ALL  = 4'hb,
      SESL_CMD_SM_RD_REG  = 4'hc,
      SESL_CMD_DEFAULTS   = 4'hd
   } sesl_cmd_type;

   // ---------------------------------------------------------------
   // answer states
   // ---------------------------------------------------------------
   typedef enum logic [0:0] {
      SESL_IDLE = 1'b0,
      SESL_ANS  = 1'b1
   } sesl_state_type;
endpackage

// ### sesl_status_summary.sv
`timescale 1ns/100ps
// Summary of operation
// - enable query returns sum of enabled weights
// - bits outside mask count as disabled
// - bit enable query, index 0..15, returns 0/1
// - global query sums weights of active registers
// - global register query returns any enabled event
// - indicator mask write replaces whole connection set
// - single indicator write changes only that register
// - indicator lit on connected enabled set event
// - indicator mask query sums connected weights
// - per-register indicator query returns 0/1
// - each register holds sixteen status bits
// - enabled events latch on rising condition
// - event reads clear whole register or one bit
module sesl_status_summary #(
   parameter int unsigned NREGS = sesl_pkg::NUM_REGS,
   parameter int unsigned RBITS = sesl_pkg::REG_BITS
) (
   input  wire logic                   clk,
   input  wire logic                   rst,
   input  wire logic [NREGS*RBITS-1:0] status_cond,
   input  wire logic                   cmd_valid,
   input  wire logic [3:0]             cmd_code,
   input  wire logic [3:0]             cmd_reg,
   input  wire logic [3:0]             cmd_bit,
   input  wire logic [15:0]            cmd_value,
   output logic                        cmd_ready,
   output logic                        rsp_valid,
   output logic [15:0]                 rsp_data,
   output logic                        rsp_error,
   output logic [NREGS-1:0]            global_summary,
   output logic                        service_led
);
   // ---------------------------------------------------------------
   // storage and decode
   // ---------------------------------------------------------------
   logic [NREGS*RBITS-1:0] enable_all;
   logic [NREGS*RBITS-1:0] events_all;
   logic [NREGS-1:0]       service_ff;
   logic [NREGS-1:0]       en_load;
   logic [15:0]            en_value;
   logic [NREGS*RBITS-1:0] ev_clear;
   logic [15:0]            nxt_rsp;
   logic                   nxt_err;
   logic [15:0]            rsp_ff;
   logic                   err_ff;
   sesl_pkg::sesl_state_type state_ff;
   sesl_pkg::sesl_state_type nxt_state;
   sesl_pkg::sesl_cmd_type   cmd;
   logic                   take;
   logic                   reg_ok;
   logic [RBITS-1:0]       sel_en;
   logic [RBITS-1:0]       sel_ev;
   logic [RBITS-1:0]       bit_mask;
   logic [NREGS-1:0]       reg_mask;

   // one-hot of an index, width 16
   function automatic logic [15:0] onehot16(input logic [3:0] idx);
      onehot16 = 16'h0001 << idx;
   endfunction

   assign cmd      = sesl_pkg::sesl_cmd_type'(cmd_code);
   assign take     = cmd_valid && cmd_ready;
   assign reg_ok   = 32'(cmd_reg) < NREGS;
   assign reg_mask = NREGS'(onehot16(cmd_reg));
   assign bit_mask = RBITS'(onehot16(cmd_bit));
   assign sel_en   = reg_ok ? enable_all[cmd_reg*RBITS +: RBITS] : '0;
   assign sel_ev   = reg_ok ? events_all[cmd_reg*RBITS +: RBITS] : '0;

   // ---------------------------------------------------------------
   // event registers
   // ---------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < NREGS; g++) begin : g_reg
         logic ld;
         logic [RBITS-1:0] clr;
         assign ld  = take && reg_ok && reg_mask[g] &&
                      (cmd == sesl_pkg::SESL_CMD_EN_WR_ALL ||
                       cmd == sesl_pkg::SESL_CMD_EN_WR_BIT);
         assign en_load[g] = ld || (take && cmd == sesl_pkg::SESL_CMD_DEFAULTS);
         // whole read clears all bits, bit read only one
         assign clr = !(take && reg_ok && reg_mask[g]) ? '0 :
                      (cmd == sesl_pkg::SESL_CMD_EV_RD_ALL) ? '1 :
                      (cmd == sesl_pkg::SESL_CMD_EV_RD_BIT) ? bit_mask : '0;
         assign ev_clear[g*RBITS +: RBITS] = clr;
         // summary bit from enabled and set events
         assign global_summary[g] = |(events_all[g*RBITS +: RBITS] &
                                      enable_all[g*RBITS +: RBITS]);
         sesl_event_reg #(
            .WIDTH    (RBITS)
         ) u_reg (
            .clk      (clk),
            .rst      (rst),
            .cond     (status_cond[g*RBITS +: RBITS]),
            .en_load  (en_load[g]),
            .en_value (RBITS'(en_value)),
            .ev_clear (ev_clear[g*RBITS +: RBITS]),
            .enable   (enable_all[g*RBITS +: RBITS]),
            .events   (events_all[g*RBITS +: RBITS])
         );
      end
   endgenerate

   // new enable word for whole or single-bit writes
   assign en_value = (cmd == sesl_pkg::SESL_CMD_DEFAULTS) ? sesl_pkg::ENABLE_RST :
                     (cmd == sesl_pkg::SESL_CMD_EN_WR_ALL) ? cmd_value :
                     cmd_value[0] ? (16'(sel_en) | 16'(bit_mask)) :
                                    (16'(sel_en) & ~16'(bit_mask));

   // indicator lamp
   assign service_led = |(global_summary & service_ff);

   // ---------------------------------------------------------------
   // indicator connection mask
   // ---------------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         service_ff <= sesl_pkg::SERVICE_RST;
      end else if (take && cmd == sesl_pkg::SESL_CMD_SM_WR_ALL) begin
         service_ff <= cmd_value[NREGS-1:0];
      end else if (take && cmd == sesl_pkg::SESL_CMD_SM_WR_REG && reg_ok) begin
         service_ff <= cmd_value[0] ? (service_ff | reg_mask)
                                    : (service_ff & ~reg_mask);
      end else if (take && cmd == sesl_pkg::SESL_CMD_DEFAULTS) begin
         service_ff <= sesl_pkg::SERVICE_RST;
      end
   end

   // ---------------------------------------------------------------
   // answer selection
   // ---------------------------------------------------------------
   always_comb begin
      nxt_rsp = 16'h0000;
      nxt_err = 1'b0;
      case (cmd)
         sesl_pkg::SESL_CMD_EN_RD_ALL: nxt_rsp = 16'(sel_en);
         sesl_pkg::SESL_CMD_EN_RD_BIT: nxt_rsp = {15'h0000, |(sel_en & bit_mask)};
         sesl_pkg::SESL_CMD_EV_RD_ALL: nxt_rsp = 16'(sel_ev);
         sesl_pkg::SESL_CMD_EV_RD_BIT: nxt_rsp = {15'h0000, |(sel_ev & bit_mask)};
         sesl_pkg::SESL_CMD_GL_RD_ALL: nxt_rsp = 16'(global_summary);
         sesl_pkg::SESL_CMD_GL_RD_REG:
            nxt_rsp = {15'h0000, reg_ok && |(global_summary & reg_mask)};
         sesl_pkg::SESL_CMD_SM_RD_ALL: nxt_rsp = 16'(service_ff);
         sesl_pkg::SESL_CMD_SM_RD_REG:
            nxt_rsp = {15'h0000, reg_ok && |(service_ff & reg_mask)};
         sesl_pkg::SESL_CMD_EN_WR_ALL,
         sesl_pkg::SESL_CMD_SM_WR_ALL,
         sesl_pkg::SESL_CMD_DEFAULTS:  nxt_rsp = 16'h0000;
         default:                      nxt_rsp = 16'h0000;
      endcase
      if (cmd != sesl_pkg::SESL_CMD_GL_RD_ALL && cmd != sesl_pkg::SESL_CMD_SM_RD_ALL &&
          cmd != sesl_pkg::SESL_CMD_SM_WR_ALL && cmd != sesl_pkg::SESL_CMD_DEFAULTS &&
          !reg_ok) begin
         nxt_err = 1'b1;
      end
      if (cmd == sesl_pkg::SESL_CMD_NONE || cmd_code > 4'hd) begin
         nxt_err = 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // answer sequencer
   // ---------------------------------------------------------------
   assign nxt_state = take ? sesl_pkg::SESL_ANS : sesl_pkg::SESL_IDLE;
   assign cmd_ready = (state_ff == sesl_pkg::SESL_IDLE);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_ff <= sesl_pkg::SESL_IDLE;
         rsp_ff   <= 16'h0000;
         err_ff   <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         if (take) begin
            rsp_ff <= nxt_rsp;
            err_ff <= nxt_err;
         end
      end
   end

   assign rsp_valid = (state_ff == sesl_pkg::SESL_ANS);
   assign rsp_data  = rsp_ff;
   assign rsp_error = err_ff;
endmodule

// ### sesl_status_summary_asserts.sv
`timescale 1ns/100ps
// ----------
// answer, summary and lamp checks
// ----------
module sesl_checker #(
   parameter int unsigned NREGS = 10
) (
   input wire logic             clk,
   input wire logic             rst,
   input wire logic             cmd_valid,
   input wire logic [3:0]       cmd_code,
   input wire logic [3:0]       cmd_reg,
   input wire logic [15:0]      cmd_value,
   input wire logic             cmd_ready,
   input wire logic             rsp_valid,
   input wire logic [15:0]      rsp_data,
   input wire logic             rsp_error,
   input wire logic [NREGS-1:0] global_summary,
   input wire logic             service_led
);
   logic             take;
   logic [NREGS-1:0] gs_ff;
   logic [3:0]       reg_ff;
   logic [NREGS-1:0] mask_ff;
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // a command is taken on this edge
   assign take = cmd_valid && cmd_ready;
   // summary and register number as seen at the taking edge
   always_ff @(posedge clk) begin
      gs_ff  <= global_summary;
      reg_ff <= cmd_reg;
   end
   // lamp connections as the host has set them
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         mask_ff <= NREGS'(sesl_pkg::SERVICE_RST);
      end else if (take && cmd_code == sesl_pkg::SESL_CMD_SM_WR_ALL) begin
         mask_ff <= cmd_value[NREGS-1:0];
      end else if (take && cmd_code == sesl_pkg::SESL_CMD_SM_WR_REG && 32'(cmd_reg) < NREGS) begin
         mask_ff[cmd_reg] <= cmd_value[0];
      end else if (take && cmd_code == sesl_pkg::SESL_CMD_DEFAULTS) begin
         mask_ff <= NREGS'(sesl_pkg::SERVICE_RST);
      end
   end
   a_answer_one_cycle:
      assert property (take |=> rsp_valid && !cmd_ready ##1 !rsp_valid)
         else $error("answer pulse wrong");
   a_global_all:
      assert property (take && cmd_code == sesl_pkg::SESL_CMD_GL_RD_ALL
         |=> rsp_data == 16'(gs_ff)) else $error("global sum wrong");
   a_global_reg:
      assert property (take && cmd_code == sesl_pkg::SESL_CMD_GL_RD_REG && cmd_reg <= 4'h9
         |=> rsp_data == {15'h0000, gs_ff[reg_ff]}) else $error("global bit wrong");
   a_bad_reg_refused:
      assert property (take && cmd_code == sesl_pkg::SESL_CMD_EN_RD_ALL && cmd_reg > 4'h9
         |=> rsp_error && rsp_data == 16'h0000) else $error("bad register accepted");
   a_good_reg_taken:
      assert property (take && cmd_code == sesl_pkg::SESL_CMD_EN_RD_ALL && cmd_reg <= 4'h9
         |=> !rsp_error) else $error("good register refused");
   a_bit_answer_binary:
      assert property (take && cmd_code inside {sesl_pkg::SESL_CMD_EN_RD_BIT,
         sesl_pkg::SESL_CMD_SM_RD_REG} |=> rsp_data[15:1] == 15'h0000)
         else $error("single bit answer too wide");
   a_mask_width:
      assert property (take && cmd_code == sesl_pkg::SESL_CMD_SM_RD_ALL
         |=> rsp_data == 16'(mask_ff)) else $error("mask answer wrong");
   a_lamp_cause:
      assert property (service_led == |(global_summary & mask_ff))
         else $error("lamp state wrong");
endmodule

bind sesl_status_summary sesl_checker #(.NREGS(NREGS)) u_sesl_checker (
   .clk(clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_reg(cmd_reg),
   .cmd_value(cmd_value),
   .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
   .rsp_error(rsp_error), .global_summary(global_summary), .service_led(service_led)
);

// ### tb_top.sv
`timescale 1ns/100ps
// ----------
// status summary bench
// ----------
module tb_top;
   typedef struct packed {
      logic [3:0]  code;
      logic [3:0]  rg;
      logic [3:0]  bt;
      logic [3:0]  err;
      logic [15:0] val;
      logic [15:0] dat;
   } sesl_row_type;
   logic         clk, rst, cmd_valid, cmd_ready, rsp_valid, rsp_error, service_led, e;
   logic [3:0]   cmd_code, cmd_reg, cmd_bit;
   logic [15:0]  cmd_value, rsp_data, d;
   logic [159:0] status_cond;
   logic [9:0]   global_summary;
   int           fails, tests_run;
   sesl_row_type r;
   // code, register, bit, error, value, answer
   sesl_row_type rows [20] = '{
      48'h1300_00a5_0000, 48'h3300_0000_00a5, 48'h23f0_0001_0000, 48'h43f0_0000_0001,
      48'h4310_0000_0000, 48'h3300_0000_80a5, 48'h9000_0205_0000, 48'ha100_0001_0000,
      48'ha000_0000_0000, 48'hb000_0000_0206, 48'hc900_0000_0001, 48'hc000_0000_0000,
      48'h3a01_0000_0000, 48'he001_0000_0000, 48'hd000_0000_0000, 48'h3300_0000_ffff,
      48'hb000_0000_0000, 48'h2300_0000_0000, 48'h3300_0000_fffe, 48'h0001_0000_0000};
   sesl_status_summary u_sesl_status_summary (
      .clk(clk), .rst(rst), .status_cond(status_cond), .cmd_valid(cmd_valid),
      .cmd_code(cmd_code), .cmd_reg(cmd_reg), .cmd_bit(cmd_bit), .cmd_value(cmd_value),
      .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
      .rsp_error(rsp_error), .global_summary(global_summary), .service_led(service_led));
   sesl_host_model u_sesl_host_model (
      .clk(clk), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
      .rsp_error(rsp_error), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
      .cmd_reg(cmd_reg), .cmd_bit(cmd_bit), .cmd_value(cmd_value));
   // one command through the host model, answer left in d and e
   task automatic ask(input logic [3:0] c, b, t, input logic [15:0] v);
      u_sesl_host_model.send(c, b, t, v, d, e);
      #1;
   endtask
   // compare and count
   task automatic check(input logic [16:0] seen, input logic [16:0] want);
      tests_run++;
      if (seen !== want) begin
         fails++;
         $display("Error at %0t: seen %h, expected %h", $time, seen, want);
      end
   endtask
   // counts and verdict
   task automatic tally_and_finish();
      $display("checks %0d, mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // 40 MHz clock
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // watchdog, far beyond the hundred or so cycles the tests need
   initial begin
      #100000;
      fails++;
      tally_and_finish();
   end
   // main sequence
   initial begin
      rst = 1'b1;
      status_cond = 160'h0;
      fails = 0;
      tests_run = 0;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      foreach (rows[i]) begin
         r = rows[i];
         ask(r.code, r.rg, r.bt, r.val);
         check({1'b0, d}, {1'b0, r.dat});
         check({16'h0000, e}, {16'h0000, r.err[0]});
      end
      $display("table test done");
      // rising condition, summary, lamp and read clearing
      @(posedge clk);
      status_cond[36] <= 1'b1;
      repeat (3) @(posedge clk);
      #1;
      check({7'h00, global_summary}, 17'h00004);
      check({16'h0000, service_led}, 17'h00000);
      ask(4'ha, 4'h2, 4'h0, 16'h0001);
      check({16'h0000, service_led}, 17'h00001);
      ask(4'h7, 4'h0, 4'h0, 16'h0000);
      check({e, d}, 17'h00004);
      ask(4'h8, 4'h2, 4'h0, 16'h0000);
      check({e, d}, 17'h00001);
      ask(4'h6, 4'h2, 4'h4, 16'h0000);
      check({e, d}, 17'h00001);
      ask(4'h5, 4'h2, 4'h0, 16'h0000);
      check({e, d}, 17'h00000);
      check({6'h00, global_summary, service_led}, 17'h00000);
      @(posedge clk);
      status_cond[36] <= 1'b0;
      repeat (2) @(posedge clk);
      status_cond[36] <= 1'b1;
      repeat (3) @(posedge clk);
      ask(4'h5, 4'h2, 4'h0, 16'h0000);
      check({e, d}, 17'h00010);
      $display("event test done");
      // reset in mid-run restores enables and lamp mask
      ask(4'h1, 4'h5, 4'h0, 16'h0000);
      check({e, d}, 17'h00000);
      ask(4'h3, 4'h5, 4'h0, 16'h0000);
      check({e, d}, 17'h00000);
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      ask(4'h3, 4'h5, 4'h0, 16'h0000);
      check({e, d}, 17'h0ffff);
      ask(4'hb, 4'h0, 4'h0, 16'h0000);
      check({e, d}, 17'h00000);
      $display("reset test done");
      tally_and_finish();
   end
endmodule
